// File: bench/ras_core_model.sv
/*
 * core sequencer model: issues one stack request per call.
 * assumes the bench calls issue() and flags software access.
 */
`timescale 1ns/1ps
module ras_core_model (
    // clock and software access
    input wire logic clk_sys_i,
    input wire logic sw_access_i,
    // sequencer requests
    output ras_pkg::ras_op_t op_o,
    output logic op_valid_o,
    output logic int_high_o,
    output logic [20:0] call_target_o,
    output logic gie_high_o,
    output logic gie_low_o
);
    // interrupts masked while software touches the stack
    assign gie_high_o = ~sw_access_i;
    assign gie_low_o = ~sw_access_i;
    // idle values
    initial
    begin
        op_o = ras_pkg::RAS_OP_NONE;
        op_valid_o = 1'b0;
        int_high_o = 1'b0;
        call_target_o = 21'h000000;
    end
    // one-cycle request, target scrambled once released
    task automatic issue(input ras_pkg::ras_op_t op,
        input logic [20:0] tgt, input logic hi);
        @(posedge clk_sys_i);
        op_o <= op;
        call_target_o <= tgt;
        int_high_o <= hi;
        op_valid_o <= 1'b1;
        @(posedge clk_sys_i);
        op_valid_o <= 1'b0;
        call_target_o <= ~tgt;
    endtask
endmodule

// File: bench/ras_stack_tb_top.sv
/*
 * bench top: directed and random stack ops with a shadow model.
 * assumes ras_core_model drives the sequencer side.
 */
`timescale 1ns/1ps
`include "ras_cfg.svh"
module ras_stack_tb_top;
    // ---------------------------------------------------------------
    // signals and shadow model
    // ---------------------------------------------------------------
    localparam ras_pkg::ras_op_t NO = ras_pkg::RAS_OP_NONE;
    localparam ras_pkg::ras_op_t CL = ras_pkg::RAS_OP_CALL;
    localparam ras_pkg::ras_op_t IT = ras_pkg::RAS_OP_INT;
    localparam ras_pkg::ras_op_t RT = ras_pkg::RAS_OP_RET;
    logic clk = 1'b0, rst_n = 1'b0, por = 1'b1, ore = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdat = 8'h00, rdat, rv, lat_h;
    logic wr_s = 1'b0, rd_s = 1'b0, opv, ihi, gh, gl;
    logic [20:0] pc, ctgt, mem [1:31];
    logic [20:0] m_pc = 21'h0;
    logic [4:0] lat_u, m_sp = 5'h0;
    logic fz, full, unf, srst, saw_srst = 1'b0;
    logic m_full = 1'b0, m_unf = 1'b0, skip = 1'b0;
    logic [31:0] seed = 32'h5b, r;
    ras_pkg::ras_op_t op, o;
    int n_mismatch = 0, num_checks = 0;
    ras_core_model u_core (.clk_sys_i(clk), .sw_access_i(wr_s | rd_s),
        .op_o(op), .op_valid_o(opv), .int_high_o(ihi),
        .call_target_o(ctgt), .gie_high_o(gh), .gie_low_o(gl));
    ras_stack #(.BIG_MEM(1'b0)) dut (.clk_sys_i(clk), .rst_n_i(rst_n),
        .por_i(por), .overflow_reset_enable_i(ore), .op_i(op),
        .op_valid_i(opv), .int_high_i(ihi), .call_target_i(ctgt),
        .global_int_enable_high_i(gh), .global_int_enable_low_i(gl),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdat), .pc_o(pc),
        .fetch_zero_o(fz), .pc_upper_latch_o(lat_u),
        .pc_high_latch_o(lat_h), .stack_full_flag_o(full),
        .stack_underflow_flag_o(unf), .stack_reset_o(srst));
    // 40 MHz clock and overflow reset monitor
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (srst)
            saw_srst <= 1'b1;
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected register bytes
    function automatic logic [7:0] ptr_exp();
        return {m_full, m_unf, 1'b0, m_sp};
    endfunction
    function automatic logic [7:0] top_exp(input logic [3:0] a);
        logic [20:0] w;
        w = mem[m_sp];
        return a == 4'h1 ? w[7:0] : a == 4'h2 ? w[15:8] : {3'h0, w[20:16]};
    endfunction
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        rv = rdat;
    endtask
    task automatic rst(input logic p);
        @(posedge clk);
        rst_n <= 1'b0;
        por <= p;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        por <= 1'b0;
        m_sp = 5'h0;
        m_pc = 21'h0;
        m_full = m_full & ~p;
        m_unf = m_unf & ~p;
    endtask
    // one sequencer op, shadow update and compare
    task automatic sop(input ras_pkg::ras_op_t k, input logic [20:0] t,
        input logic hi);
        u_core.issue(k, t, hi);
        #1;
        if (k == CL || k == IT)
        begin
            if (m_sp != 5'h1f)
            begin
                m_sp = m_sp + 5'h1;
                mem[m_sp] = m_pc;
            end
            m_full = m_full | (m_sp == 5'h1f);
            m_pc = k == CL ? t : hi ? `RAS_VEC_HIGH : `RAS_VEC_LOW;
        end
        else if (k == RT)
        begin
            m_unf = m_unf | (m_sp == 5'h0);
            m_pc = m_sp == 5'h0 ? 21'h0 : mem[m_sp];
            if (m_sp != 5'h0)
                m_sp = m_sp - 5'h1;
        end
        else
            m_pc = m_pc + `RAS_PC_STEP;
        if (!skip)
            chk(pc, m_pc);
        chk({full, unf}, {m_full, m_unf});
    endtask
    // watchdog
    initial
    begin
        #(25 * 40000);
        n_mismatch++;
        summarize();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        rst(1'b1);
        #1;
        chk(pc, `RAS_VEC_RESET);
        rd(`RAS_OFF_PTR);
        chk(rv, ptr_exp());
        rd(4'h9);
        chk(rv, 8'h00);
        wr(`RAS_OFF_CTRL, 8'ha5);
        sop(NO, 21'h0, 1'b0);
        sop(CL, 21'h000420, 1'b0);
        for (int a = 1; a < 4; a++)
        begin
            rd(4'(a));
            chk(rv, top_exp(4'(a)));
        end
        sop(IT, 21'h0, 1'b1);
        sop(IT, 21'h0, 1'b0);
        rd(`RAS_OFF_PTR);
        chk(rv, ptr_exp());
        repeat (3) sop(RT, 21'h0, 1'b0);
        chk({lat_u, lat_h}, {5'h00, 8'ha5});
        $display("test calls done");
        sop(CL, 21'h000100, 1'b0);
        wr(`RAS_OFF_TOP_LOW, 8'h3c);
        wr(`RAS_OFF_TOP_UPPER, 8'h01);
        mem[m_sp][7:0] = 8'h3c;
        mem[m_sp][20:16] = 5'h01;
        rd(`RAS_OFF_TOP_HIGH);
        chk(rv, top_exp(4'h2));
        sop(RT, 21'h0, 1'b0);
        sop(RT, 21'h0, 1'b0);
        rd(`RAS_OFF_PTR);
        chk(rv, ptr_exp());
        rst(1'b0);
        #1;
        chk(unf, 1'b1);
        wr(`RAS_OFF_PTR, 8'h00);
        m_unf = 1'b0;
        rd(`RAS_OFF_PTR);
        chk(rv, ptr_exp());
        $display("test top and underflow done");
        sop(CL, `RAS_MEM_4K, 1'b0);
        chk(fz, 1'b1);
        sop(CL, `RAS_MEM_4K - `RAS_PC_STEP, 1'b0);
        chk(fz, 1'b0);
        $display("test fetch done");
        repeat (300)
        begin
            r = rnd();
            o = ras_pkg::ras_op_t'({1'b0, r[23:22]});
            sop(m_sp > 5'd28 ? RT : o, r[20:0] & 21'h001ffe, r[24]);
            if (r[3:0] == 4'h0)
            begin
                rd(`RAS_OFF_PTR);
                chk(rv, ptr_exp());
            end
        end
        $display("test random done");
        rst(1'b1);
        for (int i = 1; i < 32; i++)
            sop(CL, 21'(i * 4), 1'b0);
        skip = 1'b1;
        sop(CL, 21'h0, 1'b0);
        skip = 1'b0;
        rd(`RAS_OFF_PTR);
        chk(rv, 8'h9f);
        sop(RT, 21'h0, 1'b0);
        ore <= 1'b1;
        rst(1'b1);
        skip = 1'b1;
        for (int i = 1; i < 32; i++)
            sop(CL, 21'(i * 4), 1'b0);
        repeat (2) @(posedge clk);
        chk(saw_srst, 1'b1);
        chk(pc, `RAS_VEC_RESET);
        rd(`RAS_OFF_PTR);
        chk(rv, 8'h80);
        // 31st push stored the pc before it (30 * 4) plus one step
        wr(`RAS_OFF_PTR, 8'h9f);
        rd(`RAS_OFF_TOP_LOW);
        chk(rv, 8'h7a);
        $display("test full done");
        summarize();
    end
endmodule

// File: pkg/ras_cfg.svh
/*
 * return address stack constants: register offsets, field positions,
 * reset values, vectors and memory sizes.
 * assumes inclusion by bare name from design files.
 */
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH

// ---------------------------------------------------------------
// register offsets on the plain register port
// ---------------------------------------------------------------
`define RAS_OFF_PTR 4'h0
`define RAS_OFF_TOP_LOW 4'h1
`define RAS_OFF_TOP_HIGH 4'h2
`define RAS_OFF_TOP_UPPER 4'h3
`define RAS_OFF_CTRL 4'h4

// ---------------------------------------------------------------
// field positions of the pointer register
// ---------------------------------------------------------------
`define RAS_PTR_FULL_BIT 7
`define RAS_PTR_UNF_BIT 6

// ---------------------------------------------------------------
// widths, depth, vectors and reset values
// ---------------------------------------------------------------
`define RAS_PC_W 21
`define RAS_SP_W 5
`define RAS_DEPTH 31
`define RAS_SP_MAX 5'h1f
`define RAS_SP_RST 5'h00
`define RAS_VEC_RESET 21'h000000
`define RAS_VEC_HIGH 21'h000008
`define RAS_VEC_LOW 21'h000018
`define RAS_MEM_4K 21'h001000
`define RAS_MEM_8K 21'h002000
`define RAS_PC_STEP 21'h000002

`endif

// File: pkg/ras_pkg.sv
/*
 * return address stack types.
 * assumes nothing of its surroundings.
 */
package ras_pkg;
    // stack operation requested by the core sequencer
    typedef enum logic [2:0] {
        RAS_OP_NONE,
        RAS_OP_CALL,
        RAS_OP_INT,
        RAS_OP_RET
    } ras_op_t;
endpackage

// File: src/ras_stack.sv
/*
 * return address stack with program counter, vectors and software
 * access to pointer and top entry over a plain register port.
 * assumes the core sequencer drives one request pulse per cycle and
 * that software masks interrupts around stack register access.
 */
`timescale 1ns/1ps
`include "ras_cfg.svh"

// What this block does
// - 21-bit program counter; fetches beyond implemented memory read zero.
// - implemented program memory is 4 or 8 Kbytes, a build choice.
// - reset vector 0000h, interrupt vectors 0008h and 0018h.
// - stack holds up to 31 return addresses of calls and interrupts.
// - push pc on call, relative call and interrupt acknowledge.
// - pop top entry into pc on any return kind.
// - calls and returns leave pc upper and high latches unchanged.
// - 31 words of 21 bits, 5-bit pointer cleared by every reset.
// - pointer zero has no storage; entries live at 1 to 31.
// - push increments pointer then writes the return address.
// - pop reads the addressed word then decrements pointer.
// - stack memory is private, outside program and data spaces.
// - software reads and writes pointer and top entry registers.
// - status bits show full or overflow, and underflow.
// - top registers always show the word at the current pointer.
// - return after software writes top registers uses written values.
// - fetch bus is separate from the data register bus.
// - acknowledged interrupt pushes pc and loads the vector.
// - full flag sets after 31 pushes; only software or power-on clears.
// - overflow reset on: 31st push stores pc+2, resets, flag stays.
// - overflow reset off: pointer holds at 31, no overwrite.
// - pop when empty loads zero, sets underflow, pointer stays zero.
module ras_stack #(
    parameter bit BIG_MEM = 1'b0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic por_i,
    // configuration
    input wire logic overflow_reset_enable_i,
    // core sequencer requests
    input wire ras_pkg::ras_op_t op_i,
    input wire logic op_valid_i,
    input wire logic int_high_i,
    input wire logic [20:0] call_target_i,
    input wire logic global_int_enable_high_i,
    input wire logic global_int_enable_low_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pc, fetch and status
    output logic [20:0] pc_o,
    output logic fetch_zero_o,
    output logic [4:0] pc_upper_latch_o,
    output logic [7:0] pc_high_latch_o,
    output logic stack_full_flag_o,
    output logic stack_underflow_flag_o,
    output logic stack_reset_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [20:0] pc;
        logic [4:0] sp;
        logic full;
        logic unf;
        logic [4:0] lat_u;
        logic [7:0] lat_h;
        logic [7:0] rdata;
        logic fzero;
        logic srst;
    } ras_state_t;

    ras_state_t r;
    ras_state_t next_r;
    // private stack storage, index 0 unused
    logic [20:0] mem [1:31];
    logic mem_we;
    logic [4:0] mem_wa;
    logic [20:0] mem_wd;
    logic [20:0] top;
    // high when a push this cycle sets the full flag
    logic full_set;

    // memory limit for zero fetch
    function automatic logic beyond(input logic [20:0] a);
        beyond = BIG_MEM ? (a >= `RAS_MEM_8K) : (a >= `RAS_MEM_4K);
    endfunction

    // word at pointer, zero when empty
    always_comb
    begin
        top = (r.sp == `RAS_SP_RST) ? '0 : mem[r.sp];
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.srst = 1'b0;
        mem_we = 1'b0;
        mem_wa = r.sp;
        mem_wd = top;
        // 30th to 31st push, or push at 31, raises the full flag
        full_set = op_valid_i && (op_i == ras_pkg::RAS_OP_CALL ||
            op_i == ras_pkg::RAS_OP_INT) && r.sp >= `RAS_SP_MAX - 5'h01;
        if (op_valid_i && (op_i == ras_pkg::RAS_OP_CALL ||
            op_i == ras_pkg::RAS_OP_INT))
        begin
            // push; latches untouched
            if (op_i == ras_pkg::RAS_OP_INT)
                next_r.pc = int_high_i ? `RAS_VEC_HIGH : `RAS_VEC_LOW;
            else
                next_r.pc = call_target_i;
            if (r.sp == `RAS_SP_MAX)
            begin
                next_r.full = 1'b1;
            end
            else if (r.sp == `RAS_SP_MAX - 5'h01)
            begin
                // 31st push
                next_r.full = 1'b1;
                mem_we = 1'b1;
                mem_wa = `RAS_SP_MAX;
                if (overflow_reset_enable_i)
                begin
                    mem_wd = r.pc + `RAS_PC_STEP;
                    next_r.sp = `RAS_SP_RST;
                    next_r.pc = `RAS_VEC_RESET;
                    next_r.srst = 1'b1;
                end
                else
                begin
                    mem_wd = r.pc;
                    next_r.sp = `RAS_SP_MAX;
                end
            end
            else
            begin
                next_r.sp = r.sp + 5'h01;
                mem_we = 1'b1;
                mem_wa = r.sp + 5'h01;
                mem_wd = r.pc;
            end
        end
        else if (op_valid_i && op_i == ras_pkg::RAS_OP_RET)
        begin
            if (r.sp == `RAS_SP_RST)
            begin
                next_r.pc = `RAS_VEC_RESET;
                next_r.unf = 1'b1;
            end
            else
            begin
                next_r.pc = top;
                next_r.sp = r.sp - 5'h01;
            end
        end
        else if (op_valid_i)
        begin
            next_r.pc = r.pc + `RAS_PC_STEP;
        end
        // software register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `RAS_OFF_PTR:
                begin
                    next_r.sp = reg_wdata_i[4:0];
                    // flags clear-only; a hardware set in the same
                    // cycle wins over the software clear
                    if (!reg_wdata_i[`RAS_PTR_FULL_BIT] && !full_set)
                        next_r.full = 1'b0;
                    if (!reg_wdata_i[`RAS_PTR_UNF_BIT] &&
                        !(op_valid_i && op_i == ras_pkg::RAS_OP_RET &&
                        r.sp == `RAS_SP_RST))
                        next_r.unf = 1'b0;
                end
                `RAS_OFF_TOP_LOW:
                begin
                    mem_we = (r.sp != `RAS_SP_RST);
                    mem_wa = r.sp;
                    mem_wd = {top[20:8], reg_wdata_i};
                end
                `RAS_OFF_TOP_HIGH:
                begin
                    mem_we = (r.sp != `RAS_SP_RST);
                    mem_wa = r.sp;
                    mem_wd = {top[20:16], reg_wdata_i, top[7:0]};
                end
                `RAS_OFF_TOP_UPPER:
                begin
                    mem_we = (r.sp != `RAS_SP_RST);
                    mem_wa = r.sp;
                    mem_wd = {reg_wdata_i[4:0], top[15:0]};
                end
                `RAS_OFF_CTRL:
                begin
                    next_r.lat_h = reg_wdata_i;
                end
                default:
                begin
                    next_r.lat_u = next_r.lat_u;
                end
            endcase
        end
        // read data, one cycle later
        next_r.rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RAS_OFF_PTR:
                    next_r.rdata = {r.full, r.unf, 1'b0, r.sp};
                `RAS_OFF_TOP_LOW:
                    next_r.rdata = top[7:0];
                `RAS_OFF_TOP_HIGH:
                    next_r.rdata = top[15:8];
                `RAS_OFF_TOP_UPPER:
                    next_r.rdata = {3'h0, top[20:16]};
                `RAS_OFF_CTRL:
                    next_r.rdata = r.lat_h;
                default:
                    next_r.rdata = 8'h00;
            endcase
        end
        next_r.fzero = beyond(next_r.pc);
    end

    // ---------------------------------------------------------------
    // registers; flags kept across non power-on resets
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            r.pc <= `RAS_VEC_RESET;
            r.sp <= `RAS_SP_RST;
            r.lat_u <= 5'h00;
            r.lat_h <= 8'h00;
            r.rdata <= 8'h00;
            r.fzero <= 1'b0;
            r.srst <= 1'b0;
            if (por_i)
            begin
                r.full <= 1'b0;
                r.unf <= 1'b0;
            end
        end
        else
        begin
            r <= next_r;
        end
    end

    // stack storage write port
    // pointer zero has no word behind it, so writes there are dropped
    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we && mem_wa != `RAS_SP_RST)
            mem[mem_wa] <= mem_wd;
    end

    // outputs straight from flops
    assign reg_rdata_o = r.rdata;
    assign pc_o = r.pc;
    assign fetch_zero_o = r.fzero;
    assign pc_upper_latch_o = r.lat_u;
    assign pc_high_latch_o = r.lat_h;
    assign stack_full_flag_o = r.full;
    assign stack_underflow_flag_o = r.unf;
    assign stack_reset_o = r.srst;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // pointer movement and stored words
    a_push_incr: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_CALL && !reg_wr_i &&
        r.sp < 5'h1e) |=> r.sp == $past(r.sp) + 5'h01)
        else $error("push did not advance pointer");
    a_push_store: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_CALL && !reg_wr_i &&
        r.sp < 5'h1e) |=> top == $past(r.pc))
        else $error("push stored wrong word");
    a_pop_decr: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_RET && !reg_wr_i &&
        r.sp != 5'h00) |=> r.sp == $past(r.sp) - 5'h01)
        else $error("pop did not drop pointer");
    a_pop_loads: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_RET) |=>
        r.pc == $past(top))
        else $error("return loaded wrong pc");
    a_under_flag: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_RET && r.sp == 5'h00) |=>
        r.unf && r.sp == 5'h00 && r.pc == 21'h000000)
        else $error("underflow mishandled");
    a_int_vector: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && op_i == ras_pkg::RAS_OP_INT) |=> r.srst ||
        r.pc == ($past(int_high_i) ? 21'h000008 : 21'h000018))
        else $error("interrupt vector wrong");

    // full, overflow and flag lifetime
    a_hold_max: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.sp == 5'h1f && op_valid_i && op_i == ras_pkg::RAS_OP_CALL &&
        !reg_wr_i) |=> r.sp == 5'h1f && r.full)
        else $error("pointer left 31 on push");
    a_no_overwrite: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.sp == 5'h1f && op_valid_i && op_i == ras_pkg::RAS_OP_CALL &&
        !reg_wr_i) |=> top == $past(top))
        else $error("push at 31 overwrote the top word");
    a_ovf_reset: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.sp == 5'h1e && overflow_reset_enable_i && op_valid_i &&
        op_i == ras_pkg::RAS_OP_CALL && !reg_wr_i) |=>
        r.srst && r.full && r.sp == 5'h00 ##1 !r.srst)
        else $error("overflow reset wrong");
    a_srst_pulse: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        r.srst |=> !r.srst)
        else $error("stack reset longer than one cycle");
    a_full_sticky: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.full && !reg_wr_i) |=> r.full)
        else $error("full flag dropped without software");
    a_unf_sticky: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.unf && !reg_wr_i) |=> r.unf)
        else $error("underflow flag dropped without software");
    a_por_flags: assert property
        (@(posedge clk_sys_i)
        (!rst_n_i && por_i) |=> !r.full && !r.unf)
        else $error("power-on reset kept a flag");

    // reset, latches, top writes and fetch
    a_reset_state: assert property
        (@(posedge clk_sys_i)
        !rst_n_i |=> r.sp == 5'h00 && r.pc == 21'h000000)
        else $error("reset left pointer or pc");
    a_latch_keep: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (op_valid_i && !reg_wr_i) |=> $stable(r.lat_h))
        else $error("latch changed by call");
    a_top_low: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_addr_i == 4'h1 && r.sp != 5'h00 && !op_valid_i)
        |=> top == {$past(top[20:8]), $past(reg_wdata_i)})
        else $error("low top write touched other bits");
    a_fetch_high: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        r.pc >= 21'h002000 |-> r.fzero)
        else $error("fetch beyond memory not zero");
    a_fetch_low: assert property
        (@(posedge clk_sys_i) disable iff (!rst_n_i)
        r.pc < 21'h001000 |-> !r.fzero)
        else $error("fetch inside memory read as zero");
endmodule
